/* hdl/mhp_pkg.sv */
/*
 * Package for the multiplexed parallel host port: style codes, reset
 * values, carrier structs and the state encoding of the access engine.
 * Assumes a single 40 MHz clock domain with all pins pre-synchronised.
 */
package mhp_pkg;

   localparam int MHP_AW = 8;
   localparam int MHP_DW = 8;

   // Reset values
   localparam logic [7:0] MHP_ADDR_RST = 8'h00;
   localparam logic [7:0] MHP_DATA_RST = 8'h00;
   localparam logic MHP_STYLE_RST = 1'b0;

   // Bus style codes: strap high selects the level-direction style
   localparam logic MHP_STYLE_DIR = 1'b1;
   localparam logic MHP_STYLE_SEP = 1'b0;

   // One-hot access phases
   typedef enum logic [2:0] {
      MHP_IDLE  = 3'b001,
      MHP_ADDR  = 3'b010,
      MHP_READ  = 3'b100
   } mhp_state_t;

   // Host pin group, as seen after synchronisation
   typedef struct packed {
      logic sel_n;
      logic address_latch_strobe;
      logic data_read_strobe;
      logic dir_wr_n;
      logic [7:0] bus_in;
   } mhp_pins_t;

   // Strobe edge events derived by the edge detector
   typedef struct packed {
      logic as_rise;
      logic as_fall;
      logic ds_rise;
      logic ds_fall;
      logic rw_rise;
   } mhp_edges_t;

   // Core side access request
   typedef struct packed {
      logic wr_stb;
      logic rd_stb;
      logic [7:0] addr;
      logic [7:0] wdata;
   } mhp_req_t;

endpackage : mhp_pkg

/* hdl/mhp_edge_det.sv */
/*
 * Edge detector for the three host strobes of the parallel port.
 * Assumes its inputs are already synchronous to ref_clk_i.
 */
`timescale 1ns/1ps
module mhp_edge_det (
   input wire logic ref_clk_i,
   input wire logic rst_n_i,
   input wire logic as_i,
   input wire logic ds_i,
   input wire logic rw_i,
   output mhp_pkg::mhp_edges_t edges_o
);
   import mhp_pkg::*;

   typedef struct packed {
      logic as_q;
      logic ds_q;
      logic rw_q;
   } mhp_ed_state_t;

   mhp_ed_state_t st_r;
   mhp_ed_state_t st_nxt;

   // Previous strobe levels; idle levels assumed low except write strobe
   always_comb begin
      st_nxt = st_r;
      st_nxt.as_q = as_i;
      st_nxt.ds_q = ds_i;
      st_nxt.rw_q = rw_i;
   end

   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         st_r <= '{as_q: 1'b0, ds_q: 1'b0, rw_q: 1'b1};
      end else begin
         st_r <= st_nxt;
      end
   end

   // Combinational edges; the main file registers them where needed
   assign edges_o.as_rise = as_i & ~st_r.as_q;
   assign edges_o.as_fall = ~as_i & st_r.as_q;
   assign edges_o.ds_rise = ds_i & ~st_r.ds_q;
   assign edges_o.ds_fall = ~ds_i & st_r.ds_q;
   assign edges_o.rw_rise = rw_i & ~st_r.rw_q;

endmodule // mhp_edge_det

/* hdl/mhp_host_port.sv */
/*
 * Device-side multiplexed address/data host port. Latches an address
 * on each address strobe and turns data strobes into core read and
 * write requests in one of two strap-selected bus styles.
 * Assumes all pins synchronous to ref_clk_i and a core that returns
 * read data combinationally on rdata_i for the latched address.
 */
`timescale 1ns/1ps
// Notes on behaviour
// (R1) The host holds device select low across a cycle to reach the core.
// (R2) The host keeps device select active while the strobes are active.
// (R3) An unselected cycle still latches the address but makes no access.
// (R4) Below the power-fail threshold select is forced off internally.
// (R5) The address is captured on the falling edge of the address strobe.
// (R6) The next rising address strobe discards the latched address.
// (R7) Every access needs its own fresh address strobe just before it.
// (R8) After an unselected attempt a new address strobe must come first.
// (R9) Direction style: direction high in data strobe reads, low writes.
// (R10) Separate style: write data is taken on the write strobe rise.
// (R11) Direction style: the device drives reads while data strobe high.
// (R12) Direction style: write data is taken on the data strobe fall.
// (R13) Separate style: read data is driven only while read strobe low.
// (R14) Strap high selects direction style; low or open selects separate.
// (R15) A read ends and the bus floats on strobe fall or rise by style.
// (R16) While reset is held low every host access is refused.
// (R17) Bus drivers float except in an active selected read phase.
module mhp_host_port (
   input wire logic ref_clk_i,
   input wire logic rst_n_i,
   input wire logic bus_style_select_i,
   input wire logic power_fail_threshold_i,
   input wire logic dev_reset_n_i,
   input wire logic sel_n_i,
   input wire logic address_latch_strobe_i,
   input wire logic data_read_strobe_i,
   input wire logic dir_wr_n_i,
   input wire logic [mhp_pkg::MHP_DW-1:0] muxed_addr_data_bus_i,
   input wire logic [mhp_pkg::MHP_DW-1:0] rdata_i,
   output logic [mhp_pkg::MHP_DW-1:0] muxed_addr_data_bus_o,
   output logic muxed_addr_data_bus_oe_n_o,
   output mhp_pkg::mhp_req_t req_o,
   output logic addr_valid_o,
   output logic style_o
);
   import mhp_pkg::*;

   typedef struct packed {
      mhp_state_t st;
      logic style;
      logic style_done;
      logic addr_ok;
      logic [7:0] addr;
      logic [7:0] dout;
      logic oe_n;
      mhp_req_t req;
   } mhp_core_state_t;

   mhp_core_state_t s_r;
   mhp_core_state_t s_nxt;
   mhp_edges_t edg;
   logic sel_ok;
   logic rd_lvl;
   logic wr_evt;

   mhp_edge_det u_edge (
      .ref_clk_i(ref_clk_i),
      .rst_n_i(rst_n_i),
      .as_i(address_latch_strobe_i),
      .ds_i(data_read_strobe_i),
      .rw_i(dir_wr_n_i),
      .edges_o(edg)
   );

   // Effective select: power fail and device reset both veto it
   assign sel_ok = ~sel_n_i & ~power_fail_threshold_i // [R4]
                 & dev_reset_n_i; // [R16]

   // Read window and write event per style
   always_comb begin
      if (s_r.style == MHP_STYLE_DIR) begin
         rd_lvl = data_read_strobe_i & dir_wr_n_i; // [R9] [R11]
         wr_evt = edg.ds_fall & ~dir_wr_n_i; // [R12] [R9]
      end else begin
         rd_lvl = ~data_read_strobe_i; // [R13]
         wr_evt = edg.rw_rise; // [R10]
      end
   end

   // Next state of the access engine
   always_comb begin
      s_nxt = s_r;
      s_nxt.req.wr_stb = 1'b0;
      s_nxt.req.rd_stb = 1'b0;
      // Strap sampled once, after reset release, never under reset
      if (!s_r.style_done) begin
         s_nxt.style = bus_style_select_i; // [R14]
         s_nxt.style_done = 1'b1;
      end
      case (s_r.st)
         MHP_IDLE: begin
            if (rd_lvl && s_r.addr_ok && !address_latch_strobe_i) begin
               // Unselected reads burn the address too
               s_nxt.addr_ok = 1'b0; // [R8] [R7]
               if (sel_ok) begin // [R3] [R1]
                  s_nxt.st = MHP_READ;
                  s_nxt.req.rd_stb = 1'b1;
                  s_nxt.req.addr = s_r.addr; // Core reads this address
                  s_nxt.dout = rdata_i;
                  s_nxt.oe_n = 1'b0; // [R17]
               end
            end else if (wr_evt && s_r.addr_ok) begin
               s_nxt.addr_ok = 1'b0; // [R8] [R7]
               if (sel_ok) begin // [R3] [R1]
                  s_nxt.req.wr_stb = 1'b1;
                  s_nxt.req.addr = s_r.addr;
                  s_nxt.req.wdata = muxed_addr_data_bus_i;
               end
            end
         end
         MHP_READ: begin
            s_nxt.req.addr = s_r.addr;
            s_nxt.dout = rdata_i;
            // Strobe end or lost select floats the bus at once
            if (!rd_lvl || !sel_ok) begin // [R15] [R2]
               s_nxt.st = MHP_IDLE;
               s_nxt.oe_n = 1'b1; // [R17]
            end
         end
         MHP_ADDR: begin
            s_nxt.oe_n = 1'b1; // [R17]
         end
         default: begin
            s_nxt.st = MHP_IDLE;
            s_nxt.oe_n = 1'b1;
         end
      endcase
      // Rise clears, fall captures, select not consulted; placed after
      // the access so a fresh capture wins over the consuming clear
      if (edg.as_rise) begin
         s_nxt.addr_ok = 1'b0; // [R6]
         s_nxt.st = MHP_ADDR;
      end else if (edg.as_fall) begin
         s_nxt.addr = muxed_addr_data_bus_i; // [R5] [R3]
         s_nxt.addr_ok = 1'b1;
         s_nxt.st = MHP_IDLE;
      end
      if (edg.as_rise || edg.as_fall) begin
         s_nxt.oe_n = 1'b1;
      end
   end

   // Single register bank, constant reset values only
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         s_r.st <= MHP_IDLE;
         s_r.style <= MHP_STYLE_RST;
         s_r.style_done <= 1'b0;
         s_r.addr_ok <= 1'b0;
         s_r.addr <= MHP_ADDR_RST;
         s_r.dout <= MHP_DATA_RST;
         s_r.oe_n <= 1'b1;
         s_r.req <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   // All outputs straight from flops
   assign muxed_addr_data_bus_o = s_r.dout;
   assign muxed_addr_data_bus_oe_n_o = s_r.oe_n;
   assign req_o = s_r.req;
   assign addr_valid_o = s_r.addr_ok;
   assign style_o = s_r.style;

   // Assertion helpers
   sequence as_fall_s;
      edg.as_fall;
   endsequence

   sequence as_rise_s;
      edg.as_rise;
   endsequence

   bus_float_a: assert property ( // [R17]
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      (s_r.st != MHP_READ) |-> muxed_addr_data_bus_oe_n_o)
      else $error("bus driven outside read phase");

   pf_block_a: assert property ( // [R4]
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      power_fail_threshold_i |=> !req_o.wr_stb && !req_o.rd_stb)
      else $error("access during power fail");

   rst_block_a: assert property ( // [R16]
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      !dev_reset_n_i |=> !req_o.wr_stb && !req_o.rd_stb)
      else $error("access during device reset");

   addr_cap_a: assert property ( // [R5]
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      as_fall_s |=> addr_valid_o
         && s_r.addr == $past(muxed_addr_data_bus_i))
      else $error("address not captured on strobe fall");

   addr_clr_a: assert property ( // [R6]
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      as_rise_s |=> !addr_valid_o)
      else $error("address kept after strobe rise");

   unsel_none_a: assert property ( // [R3]
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      sel_n_i |=> !req_o.wr_stb && !req_o.rd_stb)
      else $error("access without select");

   one_access_a: assert property ( // [R7]
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      (req_o.wr_stb && !$past(edg.as_fall)) |-> !addr_valid_o)
      else $error("address reused after write");

   sep_write_a: assert property ( // [R10]
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      (req_o.wr_stb && style_o == MHP_STYLE_SEP) |->
         $past(dir_wr_n_i) && !$past(dir_wr_n_i, 2))
      else $error("separate-style write not on strobe rise");

   dir_write_a: assert property ( // [R12]
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      (req_o.wr_stb && style_o == MHP_STYLE_DIR) |->
         !$past(data_read_strobe_i) && $past(data_read_strobe_i, 2))
      else $error("direction-style write not on strobe fall");

   read_end_a: assert property ( // [R15]
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      (s_r.st == MHP_READ && style_o == MHP_STYLE_SEP
         && data_read_strobe_i) |=> muxed_addr_data_bus_oe_n_o)
      else $error("bus not floated at read end");

endmodule // mhp_host_port

/* dv/mhp_host_model.sv */
/*
 * Behavioural host that drives the strobes of the parallel port.
 * Assumes the bench calls its tasks and wires back the device's bus.
 */
`timescale 1ns/1ps
module mhp_host_model (
   input wire logic ref_clk_i,
   input wire logic style_i,
   input wire logic [7:0] dev_bus_i,
   input wire logic dev_oe_n_i,
   output mhp_pkg::mhp_pins_t pins_o
);
   import mhp_pkg::*;
   mhp_pins_t drv = '{1'b1, 1'b0, 1'b0, 1'b1, 8'h00};
   // Wire level: device wins only while it enables its drivers
   always_comb begin
      pins_o = drv;
      if (dev_oe_n_i == 1'b0) begin
         pins_o.bus_in = dev_bus_i;
      end
   end
   // Inactive strobe levels differ by style
   task automatic idle();
      drv.sel_n <= 1'b1;
      drv.address_latch_strobe <= 1'b0;
      drv.data_read_strobe <= ~style_i;
      drv.dir_wr_n <= 1'b1;
   endtask
   // Address phase, one per access
   task automatic as_rise(input logic [7:0] a, input logic sel_n);
      @(posedge ref_clk_i);
      drv.sel_n <= sel_n; // Held through strobes
      drv.address_latch_strobe <= 1'b1;
      drv.bus_in <= a;
   endtask
   task automatic as_fall();
      @(posedge ref_clk_i);
      drv.address_latch_strobe <= 1'b0;
      repeat (2) @(posedge ref_clk_i);
      drv.bus_in <= ~drv.bus_in; // Released bus shows no stale value
      @(negedge ref_clk_i);
   endtask
   // Data held two cycles past the ending edge
   task automatic write(input logic [7:0] d);
      @(posedge ref_clk_i);
      drv.bus_in <= d;
      drv.dir_wr_n <= 1'b0;
      if (style_i) drv.data_read_strobe <= 1'b1;
      repeat (3) @(posedge ref_clk_i);
      if (style_i) drv.data_read_strobe <= 1'b0;
      else drv.dir_wr_n <= 1'b1;
      repeat (2) @(posedge ref_clk_i);
      drv.dir_wr_n <= 1'b1;
      drv.bus_in <= ~d;
      drv.sel_n <= 1'b1;
      @(negedge ref_clk_i);
   endtask
   task automatic rd_begin();
      @(posedge ref_clk_i);
      drv.sel_n <= 1'b0;
      drv.data_read_strobe <= style_i; // Read level
   endtask
   task automatic rd_end();
      @(posedge ref_clk_i);
      drv.data_read_strobe <= ~style_i;
      repeat (3) @(posedge ref_clk_i);
      drv.sel_n <= 1'b1;
      @(negedge ref_clk_i);
   endtask
endmodule // mhp_host_model

/* dv/mhp_host_port_tb.sv */
/*
 * Self-checking bench for the parallel host port.
 * Assumes the host model above and the design package.
 */
`timescale 1ns/1ps
module mhp_host_port_tb;
   import mhp_pkg::*;
   logic ref_clk_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic strap = 1'b0;
   logic pfail = 1'b0;
   logic dev_rst_n = 1'b1;
   logic [7:0] rdata = 8'h00;
   logic [7:0] bus_o;
   logic oe_n, addr_valid, style;
   mhp_pins_t pins;
   mhp_req_t req, last_req;
   int n_fail = 0, num_checks = 0, n_wr = 0, n_rd = 0, n_oe = 0, cyc = 0;
   always #12.5 ref_clk_i = ~ref_clk_i;
   mhp_host_model host (.ref_clk_i(ref_clk_i), .style_i(strap),
      .dev_bus_i(bus_o), .dev_oe_n_i(oe_n), .pins_o(pins));
   mhp_host_port uut (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
      .bus_style_select_i(strap), .power_fail_threshold_i(pfail),
      .dev_reset_n_i(dev_rst_n), .sel_n_i(pins.sel_n),
      .address_latch_strobe_i(pins.address_latch_strobe),
      .data_read_strobe_i(pins.data_read_strobe),
      .dir_wr_n_i(pins.dir_wr_n), .muxed_addr_data_bus_i(pins.bus_in),
      .rdata_i(rdata), .muxed_addr_data_bus_o(bus_o),
      .muxed_addr_data_bus_oe_n_o(oe_n), .req_o(req),
      .addr_valid_o(addr_valid), .style_o(style));
   // Counts strobes and driven cycles; a hang ends the run
   always @(posedge ref_clk_i) begin
      if (req.wr_stb === 1'b1 || req.rd_stb === 1'b1) last_req = req;
      if (req.wr_stb === 1'b1) n_wr++;
      if (req.rd_stb === 1'b1) n_rd++;
      if (oe_n !== 1'b1) n_oe++;
      cyc++;
      if (cyc == 3000) begin
         n_fail++;
         stop_test();
      end
   end
   task automatic chk(input string what, input logic [7:0] seen, exp);
      num_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic do_reset(input logic st);
      @(posedge ref_clk_i);
      rst_n_i <= 1'b0;
      strap <= st;
      // Idle levels follow the new strap, so set them an edge later
      @(posedge ref_clk_i);
      host.idle();
      repeat (11) @(posedge ref_clk_i);
      rst_n_i <= 1'b1;
      repeat (3) @(negedge ref_clk_i);
      chk("style", style, st);
   endtask
   task automatic addr_phase(input logic [7:0] a, input logic sel_n);
      host.as_rise(a, sel_n);
      repeat (2) @(negedge ref_clk_i);
      chk("valid after rise", addr_valid, 1'b0);
      host.as_fall();
      chk("valid after fall", addr_valid, 1'b1);
   endtask
   // Selected write then read, each behind its own address strobe
   task automatic t_access(input logic st, input logic [7:0] a, d);
      int w0, r0, i;
      do_reset(st);
      w0 = n_wr;
      r0 = n_rd;
      addr_phase(a, 1'b0);
      host.write(d);
      chk("wr count", 8'(n_wr - w0), 8'h01);
      chk("wr addr", last_req.addr, a);
      chk("wr data", last_req.wdata, d);
      chk("addr used", addr_valid, 1'b0);
      @(posedge ref_clk_i) rdata <= ~d;
      addr_phase(a + 8'h01, 1'b0);
      host.rd_begin();
      for (i = 0; i < 5 && oe_n !== 1'b0; i++) @(negedge ref_clk_i);
      chk("read drive", oe_n, 1'b0);
      chk("read data", bus_o, ~d);
      host.rd_end();
      chk("float", oe_n, 1'b1);
      chk("rd addr", last_req.addr, a + 8'h01);
      chk("rd count", 8'(n_rd - r0), 8'h01);
      $display("test access style %0d done", st);
   endtask
   // Unselected, power-fail and device-reset attempts are refused
   task automatic t_refused();
      int w0, r0, o0, k;
      do_reset(1'b0);
      for (k = 0; k < 3; k++) begin
         @(posedge ref_clk_i);
         pfail <= (k == 1);
         dev_rst_n <= (k != 2);
         w0 = n_wr;
         r0 = n_rd;
         o0 = n_oe;
         addr_phase(8'h10 + 8'(k), k == 0);
         host.write(8'h77);
         host.rd_begin(); // Selected read with no fresh address
         host.rd_end();
         chk("no write", 8'(n_wr - w0), 8'h00);
         chk("no read", 8'(n_rd - r0), 8'h00);
         chk("no drive", 8'(n_oe - o0), 8'h00);
      end
      $display("test refused done");
   endtask
   task automatic stop_test();
      $display("checks %0d mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   initial begin
      t_access(1'b1, 8'h3C, 8'hA5);
      t_access(1'b0, 8'hC3, 8'h5A);
      t_refused();
      stop_test();
   end
endmodule // mhp_host_port_tb
